// *** src/tx_coding_defines.vh ***
// Constants for the 100 Mb/s transmit coding path and its management slave
//
// Function
// RL1 - MAC presents one 4-bit transmit nibble per transmit clock.
// RL2 - Each data nibble maps to one of sixteen 5-bit data code groups.
// RL3 - First two preamble nibbles are replaced by the J then K delimiter.
// RL4 - Later preamble and data nibbles become code groups in arrival order.
// RL5 - Dropping transmit enable appends the T then R delimiter pair.
// RL6 - Idle code groups fill every gap until the next packet.
// RL7 - Code groups are serialized, scrambled, NRZI coded, then MLT-3 coded.
// RL8 - Odd nibble count with forwarding on adds one error nibble before the end.
// RL9 - Bit 1 of switch_config_two turns forwarding off; no padding then.
// RL10 - MLT-3 changes level for a one and holds level for a zero.
// RL11 - Scrambler seed is derived from the management address.
// RL12 - Transmit error during enable replaces the nibble with the error symbol.
// RL13 - NRZI toggles for each scrambled one, holds for each zero.
`ifndef TX_CODING_DEFINES_VH
`define TX_CODING_DEFINES_VH

// Register map
`define SWITCH_CONFIG_TWO_ADDR 5'h0a
`define SWITCH_CONFIG_TWO_RESET 16'h0000
`define FWD_DISABLE_BIT 1

// Management frame fields
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_DATA_BITS 5'h10

// Control code groups
`define CG_IDLE 5'h1f
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0d
`define CG_R 5'h07
`define CG_H 5'h04

// Scrambler
`define SCR_WIDTH 11
`define SCR_TAP_HI 10
`define SCR_TAP_LO 8

// Line levels of the MLT-3 output
`define LVL_ZERO 2'h0
`define LVL_PLUS 2'h1
`define LVL_MINUS 2'h3

`endif

// *** src/line_coder.v ***
// Scrambler, NRZI and MLT-3 stages, five code bits per clock
`timescale 1ns/1ps
`include "tx_coding_defines.vh"
module line_coder (
    input wire clock_in,
    input wire reset_in,
    input wire [`SCR_WIDTH-1:0] seed_in,
    input wire [4:0] code_group_in,
    output reg [4:0] nrzi_bits_out,
    output reg [9:0] line_levels_out
);
    reg [`SCR_WIDTH-1:0] lfsr_reg;
    reg [`SCR_WIDTH-1:0] lfsr_next;
    reg nrzi_reg;
    reg nrzi_next;
    reg [1:0] level_reg;
    reg [1:0] level_next;
    reg last_nonzero_reg;
    reg last_nonzero_next;
    reg [4:0] nrzi_bits_next;
    reg [9:0] levels_next;
    reg feedback;
    reg scrambled;
    integer i;

    // Bit 4 of the code group goes on the line first
    always @* begin
        lfsr_next = lfsr_reg;
        nrzi_next = nrzi_reg;
        level_next = level_reg;
        last_nonzero_next = last_nonzero_reg;
        nrzi_bits_next = 5'h00;
        levels_next = 10'h000;
        feedback = 1'b0;
        scrambled = 1'b0;
        for (i = 4; i >= 0; i = i - 1) begin
            feedback = lfsr_next[`SCR_TAP_HI] ^ lfsr_next[`SCR_TAP_LO];
            scrambled = code_group_in[i] ^ feedback; // RL7
            lfsr_next = {lfsr_next[`SCR_WIDTH-2:0], feedback};
            nrzi_next = nrzi_next ^ scrambled; // RL13
            if (nrzi_next) begin
                if (level_next != `LVL_ZERO) begin // RL10
                    last_nonzero_next = (level_next == `LVL_PLUS);
                    level_next = `LVL_ZERO;
                end else begin
                    level_next = last_nonzero_next ? `LVL_MINUS : `LVL_PLUS;
                end
            end
            nrzi_bits_next[i] = nrzi_next;
            levels_next[2*i+1 -: 2] = level_next;
        end
    end

    always @(posedge clock_in) begin
        if (reset_in) begin
            lfsr_reg <= seed_in; // RL11
            nrzi_reg <= 1'b0;
            level_reg <= `LVL_ZERO;
            last_nonzero_reg <= 1'b0;
            nrzi_bits_out <= 5'h00;
            line_levels_out <= 10'h000;
        end else begin
            lfsr_reg <= lfsr_next;
            nrzi_reg <= nrzi_next;
            level_reg <= level_next;
            last_nonzero_reg <= last_nonzero_next;
            nrzi_bits_out <= nrzi_bits_next;
            line_levels_out <= levels_next;
        end
    end
endmodule

// *** src/tx_coding_path.v ***
// Transmit coding path: MII encoder, management slave and line coder
`timescale 1ns/1ps
`include "tx_coding_defines.vh"
module tx_coding_path (
    input wire clock_in,
    input wire reset_in,
    input wire tx_en_in,
    input wire tx_er_in,
    input wire [3:0] txd_in,
    input wire [4:0] phy_address_in,
    input wire mdc_in,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_out,
    output reg [4:0] code_group_out,
    output wire [4:0] nrzi_bits_out,
    output wire [9:0] line_levels_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SSD_K = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_ESD_T = 3'h3;
    localparam ST_ESD_R = 3'h4;

    localparam M_IDLE = 3'h0;
    localparam M_START = 3'h1;
    localparam M_HEAD = 3'h2;
    localparam M_TA = 3'h3;
    localparam M_DATA = 3'h4;

    // Data code group of one nibble
    function [4:0] encode_nibble;
        input [3:0] nib;
        begin
            case (nib)
                4'h0: encode_nibble = 5'h1e;
                4'h1: encode_nibble = 5'h09;
                4'h2: encode_nibble = 5'h14;
                4'h3: encode_nibble = 5'h15;
                4'h4: encode_nibble = 5'h0a;
                4'h5: encode_nibble = 5'h0b;
                4'h6: encode_nibble = 5'h0e;
                4'h7: encode_nibble = 5'h0f;
                4'h8: encode_nibble = 5'h12;
                4'h9: encode_nibble = 5'h13;
                4'ha: encode_nibble = 5'h16;
                4'hb: encode_nibble = 5'h17;
                4'hc: encode_nibble = 5'h1a;
                4'hd: encode_nibble = 5'h1b;
                4'he: encode_nibble = 5'h1c;
                default: encode_nibble = 5'h1d;
            endcase
        end
    endfunction

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg odd_reg;
    reg odd_next;
    reg [4:0] code_next;
    reg [15:0] switch_config_two_reg;
    wire forward_enable;

    reg [4:0] addr_sync1_reg;
    reg [4:0] addr_sync2_reg;
    reg [4:0] phy_addr_reg;
    reg mdc_sync1_reg;
    reg mdc_sync2_reg;
    reg mdc_prev_reg;
    reg mdio_sync1_reg;
    reg mdio_sync2_reg;
    wire mdc_rise;

    reg [2:0] mstate_reg;
    reg [4:0] mcount_reg;
    reg [11:0] head_reg;
    reg [15:0] mdata_reg;
    reg mdio_prev_reg;
    reg mread_reg;
    reg mselect_reg;

    assign forward_enable = ~switch_config_two_reg[`FWD_DISABLE_BIT]; // RL9

    // Encoder consumes one nibble per clock
    always @* begin
        state_next = state_reg;
        odd_next = odd_reg;
        code_next = `CG_IDLE; // RL6
        case (state_reg)
            ST_IDLE: begin
                if (tx_en_in) begin // RL1
                    code_next = `CG_J; // RL3
                    state_next = ST_SSD_K;
                end
            end
            ST_SSD_K: begin
                code_next = `CG_K; // RL3
                odd_next = 1'b0;
                state_next = ST_DATA;
            end
            ST_DATA: begin
                if (tx_en_in) begin
                    odd_next = ~odd_reg;
                    if (tx_er_in) begin
                        code_next = `CG_H; // RL12
                    end else begin
                        code_next = encode_nibble(txd_in); // RL2 RL4
                    end
                end else if (odd_reg && forward_enable) begin
                    code_next = `CG_H; // RL8
                    state_next = ST_ESD_T;
                end else begin
                    code_next = `CG_T; // RL5
                    state_next = ST_ESD_R;
                end
            end
            ST_ESD_T: begin
                code_next = `CG_T; // RL5
                state_next = ST_ESD_R;
            end
            ST_ESD_R: begin
                code_next = `CG_R; // RL5
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            odd_reg <= 1'b0;
            code_group_out <= `CG_IDLE;
        end else begin
            state_reg <= state_next;
            odd_reg <= odd_next;
            code_group_out <= code_next;
        end
    end

    // Address straps and management pins are resynchronized
    always @(posedge clock_in) begin
        addr_sync1_reg <= phy_address_in;
        addr_sync2_reg <= addr_sync1_reg;
        mdc_sync1_reg <= mdc_in;
        mdc_sync2_reg <= mdc_sync1_reg;
        mdio_sync1_reg <= mdio_in;
        mdio_sync2_reg <= mdio_sync1_reg;
    end

    always @(posedge clock_in) begin
        if (reset_in) begin
            phy_addr_reg <= addr_sync2_reg;
            mdc_prev_reg <= 1'b0;
        end else begin
            mdc_prev_reg <= mdc_sync2_reg;
        end
    end

    assign mdc_rise = mdc_sync2_reg & ~mdc_prev_reg;

    // Management frame slave, sampled on MDC rising edges
    always @(posedge clock_in) begin
        if (reset_in) begin
            mstate_reg <= M_IDLE;
            mcount_reg <= 5'h00;
            head_reg <= 12'h000;
            mdata_reg <= 16'h0000;
            mdio_prev_reg <= 1'b1;
            mread_reg <= 1'b0;
            mselect_reg <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_out <= 1'b0;
            switch_config_two_reg <= `SWITCH_CONFIG_TWO_RESET;
        end else if (mdc_rise) begin
            mdio_prev_reg <= mdio_sync2_reg;
            case (mstate_reg)
                M_IDLE: begin
                    if (mdio_prev_reg && !mdio_sync2_reg) begin
                        mstate_reg <= M_START;
                    end
                end
                M_START: begin
                    mcount_reg <= 5'h00;
                    mstate_reg <= mdio_sync2_reg ? M_HEAD : M_IDLE;
                end
                M_HEAD: begin
                    head_reg <= {head_reg[10:0], mdio_sync2_reg};
                    mcount_reg <= mcount_reg + 5'h01;
                    if (mcount_reg == 5'h0b) begin
                        mread_reg <= (head_reg[10:9] == `MGMT_OP_READ);
                        mselect_reg <= (head_reg[8:4] == phy_addr_reg);
                        if (head_reg[10:9] != `MGMT_OP_READ &&
                            head_reg[10:9] != `MGMT_OP_WRITE) begin
                            mstate_reg <= M_IDLE;
                        end else begin
                            mstate_reg <= M_TA;
                        end
                        if ({head_reg[3:0], mdio_sync2_reg} == `SWITCH_CONFIG_TWO_ADDR) begin
                            mdata_reg <= switch_config_two_reg;
                        end else begin
                            mdata_reg <= 16'h0000;
                        end
                        head_reg[4:0] <= {head_reg[3:0], mdio_sync2_reg};
                        mcount_reg <= 5'h00;
                    end
                end
                M_TA: begin
                    mcount_reg <= mcount_reg + 5'h01;
                    if (mcount_reg == 5'h00) begin
                        mdio_out <= 1'b0;
                        mdio_oe_out <= mread_reg & mselect_reg;
                    end else begin
                        mcount_reg <= 5'h00;
                        mstate_reg <= M_DATA;
                        mdio_out <= mdata_reg[15];
                    end
                end
                M_DATA: begin
                    mcount_reg <= mcount_reg + 5'h01;
                    if (mread_reg) begin
                        mdata_reg <= {mdata_reg[14:0], 1'b0};
                        mdio_out <= mdata_reg[14];
                    end else begin
                        mdata_reg <= {mdata_reg[14:0], mdio_sync2_reg};
                    end
                    if (mcount_reg == `MGMT_DATA_BITS - 5'h01) begin
                        mstate_reg <= M_IDLE;
                        mdio_oe_out <= 1'b0;
                        mdio_out <= 1'b1;
                        mdio_prev_reg <= 1'b1;
                        if (!mread_reg && mselect_reg &&
                            head_reg[4:0] == `SWITCH_CONFIG_TWO_ADDR) begin
                            switch_config_two_reg <= {mdata_reg[14:0], mdio_sync2_reg}; // RL9
                        end
                    end
                end
                default: begin
                    mstate_reg <= M_IDLE;
                end
            endcase
        end
    end

    line_coder coder (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .seed_in({phy_addr_reg, ~phy_addr_reg, 1'b1}), // RL11
        .code_group_in(code_group_out), // RL7
        .nrzi_bits_out(nrzi_bits_out),
        .line_levels_out(line_levels_out)
    );
endmodule

// *** verification/tx_coding_path_properties.sv ***
// Checker for the transmit coding path ports
`timescale 1ns/1ps
`include "tx_coding_defines.vh"
module tx_coding_path_properties (
    input wire clock_in,
    input wire reset_in,
    input wire tx_en_in,
    input wire tx_er_in,
    input wire mdio_oe_out,
    input wire [4:0] code_group_out,
    input wire [4:0] nrzi_bits_out,
    input wire [9:0] line_levels_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    logic [2:0] en_d = 3'h0;
    logic [1:0] last_lvl = 2'h0;
    wire [4:0] c = code_group_out;
    wire [9:0] v = line_levels_out;
    wire mid = tx_en_in && en_d[1:0] == 2'h3;
    always @(posedge clock_in) begin
        en_d <= {en_d[1:0], tx_en_in};
        last_lvl <= v[1:0];
    end
    sequence s_jk;
        c == `CG_J ##1 c == `CG_K;
    endsequence
    sequence s_tr;
        c == `CG_T ##1 c == `CG_R;
    endsequence
    sequence s_htr;
        c == `CG_H ##1 s_tr;
    endsequence
    AST_JK: assert property ($rose(tx_en_in) |=> s_jk)
        else $error("start delimiter wrong");
    AST_END: assert property ($fell(tx_en_in) |=> s_tr or s_htr)
        else $error("end delimiter wrong");
    AST_DATA: assert property (mid && !tx_er_in |=> c >= 5'h09 &&
        !(c inside {5'h0c, 5'h0d, 5'h10, 5'h11, 5'h18, 5'h19, 5'h1f}))
        else $error("data nibble not a data group");
    AST_ERR: assert property (mid && tx_er_in |=> c == `CG_H)
        else $error("error nibble not replaced");
    AST_IDLE: assert property (!tx_en_in && en_d == 3'h0 |=> c == `CG_IDLE)
        else $error("idle missing in gap");
    AST_MLT_IN: assert property (((v[9:8] != v[7:6]) == nrzi_bits_out[3]) &&
        ((v[3:2] != v[1:0]) == nrzi_bits_out[0]) && v[9:8] != 2'h2)
        else $error("line level step wrong");
    AST_MLT_X: assert property ((v[9:8] != last_lvl) == nrzi_bits_out[4])
        else $error("line level across cycles wrong");
    AST_RST: assert property (disable iff (1'b0) reset_in |=> c == `CG_IDLE &&
        nrzi_bits_out == 5'h00 && v == 10'h000 && !mdio_oe_out)
        else $error("reset outputs wrong");
endmodule
bind tx_coding_path tx_coding_path_properties tx_coding_path_properties_inst (
    .clock_in(clock_in), .reset_in(reset_in), .tx_en_in(tx_en_in),
    .tx_er_in(tx_er_in), .mdio_oe_out(mdio_oe_out), .code_group_out(code_group_out),
    .nrzi_bits_out(nrzi_bits_out), .line_levels_out(line_levels_out));

// *** verification/mac_model.sv ***
// MAC side model driving the MII transmit nibbles
`timescale 1ns/1ps
module mac_model (
    input wire clock_in,
    output logic tx_en_out,
    output logic tx_er_out,
    output logic [3:0] txd_out
);
    initial begin
        {tx_en_out, tx_er_out, txd_out} = 6'h00;
    end
    // One nibble per clock; noise on the lines while disabled
    task automatic put(input logic en, input logic er, input logic [3:0] d,
                       input logic [4:0] noise);
        @(negedge clock_in);
        tx_en_out = en;
        tx_er_out = en ? er : noise[4];
        txd_out = en ? d : noise[3:0];
    endtask
endmodule

// *** verification/tx_coding_path_tb.sv ***
// Self-checking bench for the transmit coding path
`timescale 1ns/1ps
`include "tx_coding_defines.vh"
module tx_coding_path_tb;
    localparam logic [4:0] ADDR = 5'h05;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic mdc = 1'b0, sta_oe = 1'b0, sta_d = 1'b1, fwd = 1'b1, fb;
    logic [31:0] rng = 32'h6174c373;
    logic [4:0] q[$];
    logic [10:0] lf;
    logic nz;
    logic [4:0] ne;
    logic [9:0] le;
    logic [1:0] lv;
    logic ln;
    logic [15:0] r;
    int n_mismatch = 0, total_checks = 0, rel = 0;
    wire tx_en, tx_er, mdio_out, mdio_oe;
    wire [3:0] txd;
    wire [4:0] code, nrzi;
    wire [9:0] lvl;
    wire line = mdio_oe ? mdio_out : (sta_oe ? sta_d : 1'b1);
    logic [4:0] tbl [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    always #25 clock_in = ~clock_in;
    mac_model mac_model_inst (.clock_in(clock_in), .tx_en_out(tx_en), .tx_er_out(tx_er),
        .txd_out(txd));
    tx_coding_path tx_coding_path_inst (.clock_in(clock_in), .reset_in(reset_in),
        .tx_en_in(tx_en), .tx_er_in(tx_er), .txd_in(txd), .phy_address_in(ADDR),
        .mdc_in(mdc), .mdio_in(line), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe),
        .code_group_out(code), .nrzi_bits_out(nrzi), .line_levels_out(lvl));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        total_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        rel <= reset_in ? 0 : rel + 1;
        #1;
        if (q.size() > 0) chk(code, q.pop_front());
    end
    // Line model: one code group through scrambler, NRZI and MLT-3
    task automatic line_step(input logic [4:0] cg);
        for (int i = 4; i >= 0; i--) begin
            fb = lf[10] ^ lf[8];
            lf = {lf[9:0], fb};
            nz = nz ^ cg[i] ^ fb;
            ne[i] = nz;
            if (nz) begin
                if (lv != `LVL_ZERO) begin
                    ln = (lv == `LVL_PLUS);
                    lv = `LVL_ZERO;
                end else begin
                    lv = ln ? `LVL_MINUS : `LVL_PLUS;
                end
            end
            le[2*i+1 -: 2] = lv;
        end
    endtask
    // The coder takes in the reset idle group at the first edge after release
    always @(negedge clock_in) begin
        if (rel == 0) begin
            lf = {ADDR, ~ADDR, 1'b1};
            nz = 1'b0;
            lv = `LVL_ZERO;
            ln = 1'b0;
            line_step(`CG_IDLE);
        end else begin
            chk(nrzi, ne);
            chk(lvl, le);
            line_step(code);
        end
    end
    task automatic pkt(input int n, input logic er_on);
        logic [3:0] d;
        logic er;
        logic [4:0] tl[$];
        for (int i = 0; i < n; i++) begin
            rng = xs(rng);
            d = rng[3:0];
            er = er_on && i == n - 2;
            mac_model_inst.put(1'b1, er, d, rng[8:4]);
            q.push_back(i == 0 ? `CG_J : i == 1 ? `CG_K : er ? `CG_H : tbl[d]);
        end
        if (fwd && (n % 2 == 1)) tl.push_back(`CG_H);
        tl.push_back(`CG_T);
        tl.push_back(`CG_R);
        foreach (tl[k]) begin
            rng = xs(rng);
            mac_model_inst.put(1'b0, 1'b0, 4'h0, rng[4:0]);
            q.push_back(tl[k]);
        end
    endtask
    task automatic mbit(input logic b, input logic oe, output logic s);
        sta_d = b;
        sta_oe = oe;
        repeat (4) @(negedge clock_in);
        s = line;
        mdc = 1'b1;
        repeat (4) @(negedge clock_in);
        mdc = 1'b0;
    endtask
    task automatic mfr(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
        logic [39:0] f;
        logic s;
        f = {8'hff, 2'h1, rd ? 2'h2 : 2'h1, pa, ra, 2'h2, wd};
        for (int i = 39; i >= 0; i--) begin
            mbit(f[i], !(rd && i < 18), s);
            if (i < 16) rdat[i] = s;
        end
        @(negedge clock_in);
        sta_oe = 1'b0;
    endtask
    task automatic burst;
        for (int p = 0; p < 6; p++) pkt(3 + p, p == 4);
        for (int k = 0; k < 3; k++) begin
            mac_model_inst.put(1'b0, 1'b0, 4'h0, 5'h15);
            q.push_back(`CG_IDLE);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (12) @(negedge clock_in);
        reset_in = 1'b0;
        burst();
        mfr(1'b1, ADDR, `SWITCH_CONFIG_TWO_ADDR, 16'h0000, r);
        chk(r, `SWITCH_CONFIG_TWO_RESET);
        mfr(1'b0, ADDR, `SWITCH_CONFIG_TWO_ADDR, 16'h0002, r);
        mfr(1'b1, ADDR, `SWITCH_CONFIG_TWO_ADDR, 16'h0000, r);
        chk(r, 16'h0002);
        mfr(1'b1, ADDR, 5'h1f, 16'h0000, r);
        chk(r, 16'h0000);
        mfr(1'b1, ADDR ^ 5'h01, `SWITCH_CONFIG_TWO_ADDR, 16'h0000, r);
        chk(r, 16'hffff);
        fwd = 1'b0;
        burst();
        repeat (3) @(negedge clock_in);
        chk(16'(q.size()), 16'h0000);
        wrap_up();
    end
endmodule
